// File: tlcs_ctrl.sv
// Transmit loop control and status pin logic with mode register.
`timescale 1ns/1ps

module tlcs_ctrl #(
  parameter int SYNC_STAGES = 3
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_reset_n_pin,
  input wire logic i_hitless_switch_enable,
  input wire logic [1:0] i_mode_sel,
  input wire logic i_diff_out0_enable,
  input wire logic i_diff_out1_enable,
  input wire logic i_loop_locked,
  input wire logic i_rx_ref_sel,
  input wire tlcs_pkg::tlcs_reg_req_s i_reg_req,
  input wire logic [31:0] i_synth1_clock_a_hz,
  input wire logic [31:0] i_synth1_clock_b_hz,
  input wire logic [31:0] i_synth0_frame_pulse_b_hz,
  input wire logic i_synth_cfg_wr,
  output logic o_device_reset,
  output logic o_hitless_switch,
  output logic o_realign_pulse,
  output logic [1:0] o_tx_loop_mode,
  output logic o_diff_out0_drive,
  output logic o_diff_out1_drive,
  output logic o_lock,
  output logic o_hold,
  output logic o_ref_out,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  output tlcs_pkg::tlcs_synth_cfg_s o_synth_cfg
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  localparam int NPIN = 8;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_st;

  assign pin_raw = {i_rx_ref_sel, i_loop_locked, i_diff_out1_enable,
                    i_diff_out0_enable, i_mode_sel, i_hitless_switch_enable,
                    i_reset_n_pin};

  // A change counts once the second and third stages agree.
  genvar g;
  generate
    for (g = 0; g < NPIN; g++) begin : g_sync
      // Each pin keeps its own stages, so no register has two writers.
      logic [SYNC_STAGES-1:0] stage_ff;
      logic seen_ff;
      always_ff @(posedge i_clk or posedge i_reset) begin
        if (i_reset) begin
          stage_ff <= '0;
          seen_ff <= 1'b0;
        end else begin
          stage_ff <= {stage_ff[SYNC_STAGES-2:0], pin_raw[g]};
          if (stage_ff[1] == stage_ff[2]) begin
            seen_ff <= stage_ff[2];
          end
        end
      end
      assign pin_st[g] = seen_ff;
    end
  endgenerate

  logic rst_pin_n;
  logic hs_pin;
  logic [1:0] mode_pin;
  assign rst_pin_n = pin_st[0];
  assign hs_pin = pin_st[1];
  assign mode_pin = pin_st[3:2];

  // ==========================================================================
  // Device reset from the reset pin
  // ==========================================================================
  logic dev_rst;
  assign dev_rst = !rst_pin_n;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_device_reset <= 1'b1;
    end else begin
      o_device_reset <= dev_rst;
    end
  end

  // ==========================================================================
  // Mode register
  // ==========================================================================
  logic [7:0] mode_reg_ff;
  logic [7:0] nxt_mode_reg;
  logic reg_hit;
  assign reg_hit = i_reg_req.addr == tlcs_pkg::TX_LOOP_MODE_ADDR;

  always_comb begin
    nxt_mode_reg = mode_reg_ff;
    if (dev_rst) begin
      nxt_mode_reg = tlcs_pkg::TX_LOOP_MODE_RESET;
      nxt_mode_reg[tlcs_pkg::MODE_MSB:tlcs_pkg::MODE_LSB] = mode_pin;
    end else if (i_reg_req.wr && reg_hit) begin
      nxt_mode_reg = i_reg_req.wdata;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mode_reg_ff <= tlcs_pkg::TX_LOOP_MODE_RESET;
    end else begin
      mode_reg_ff <= nxt_mode_reg;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_req.rd;
      if (i_reg_req.rd && reg_hit) begin
        o_reg_rdata <= mode_reg_ff;
      end else begin
        o_reg_rdata <= 8'h00;
      end
    end
  end

  // ==========================================================================
  // Loop mode, hitless control and indicators
  // ==========================================================================
  logic [1:0] eff_mode;
  logic eff_hs;
  logic hs_d_ff;

  // Bit 7 hands mode to the register; clear means the pins steer live.
  assign eff_mode = (dev_rst || !mode_reg_ff[tlcs_pkg::MODE_SRC_BIT]) ?
      (dev_rst ? mode_pin : mode_pin) :
      mode_reg_ff[tlcs_pkg::MODE_MSB:tlcs_pkg::MODE_LSB];
  assign eff_hs = mode_reg_ff[tlcs_pkg::HITLESS_SRC_BIT] ?
      mode_reg_ff[tlcs_pkg::HITLESS_SW_BIT] : hs_pin;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_tx_loop_mode <= 2'h0;
      o_hitless_switch <= 1'b0;
      o_realign_pulse <= 1'b0;
      hs_d_ff <= 1'b0;
      o_hold <= 1'b0;
      o_lock <= 1'b0;
    end else begin
      o_tx_loop_mode <= eff_mode;
      hs_d_ff <= eff_hs;
      o_hitless_switch <= eff_hs && !dev_rst;
      o_realign_pulse <= !eff_hs && hs_d_ff && !dev_rst;
      o_hold <= !dev_rst &&
                eff_mode == tlcs_pkg::TLCS_MODE_HOLDOVER;
      o_lock <= !dev_rst && pin_st[6] &&
                eff_mode != tlcs_pkg::TLCS_MODE_HOLDOVER &&
                eff_mode != tlcs_pkg::TLCS_MODE_FREERUN;
    end
  end

  // ==========================================================================
  // Output drivers and reference copy
  // ==========================================================================
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_diff_out0_drive <= 1'b0;
      o_diff_out1_drive <= 1'b0;
      o_ref_out <= 1'b0;
    end else begin
      o_diff_out0_drive <= pin_st[4];
      o_diff_out1_drive <= pin_st[5];
      o_ref_out <= pin_st[7];
    end
  end

  // ==========================================================================
  // Synthesizer frequency configuration
  // ==========================================================================
  logic a_ok;
  logic b_ok;
  assign a_ok = (i_synth1_clock_a_hz == 32'(tlcs_pkg::SYNTH_LOW_HZ)) ||
      (i_synth1_clock_a_hz != 32'h0000_0000 &&
       i_synth1_clock_a_hz <= 32'(tlcs_pkg::SYNTH_MAX_HZ) &&
       (i_synth1_clock_a_hz % 32'(tlcs_pkg::SYNTH_STEP_HZ)) ==
       32'h0000_0000);
  assign b_ok = i_synth1_clock_b_hz >= 32'(tlcs_pkg::SYNTH_LOW_HZ) &&
      i_synth1_clock_b_hz <= 32'(tlcs_pkg::SYNTH_MAX_HZ) &&
      ((i_synth1_clock_b_hz >= i_synth1_clock_a_hz &&
        i_synth1_clock_b_hz % i_synth1_clock_a_hz == 32'h0000_0000) ||
       (i_synth1_clock_b_hz < i_synth1_clock_a_hz &&
        i_synth1_clock_a_hz % i_synth1_clock_b_hz ==
        32'h0000_0000));

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_synth_cfg.clk_a_hz <= 32'(tlcs_pkg::SYNTH1_A_DEF_HZ);
      o_synth_cfg.clk_b_hz <= 32'(tlcs_pkg::SYNTH1_B_DEF_HZ);
      o_synth_cfg.frame_hz <= 32'(tlcs_pkg::FRAME_DEF_HZ);
    end else if (dev_rst) begin
      o_synth_cfg.clk_a_hz <= 32'(tlcs_pkg::SYNTH1_A_DEF_HZ);
      o_synth_cfg.clk_b_hz <= 32'(tlcs_pkg::SYNTH1_B_DEF_HZ);
      o_synth_cfg.frame_hz <= 32'(tlcs_pkg::FRAME_DEF_HZ);
    end else if (i_synth_cfg_wr && a_ok && b_ok) begin
      o_synth_cfg.clk_a_hz <= i_synth1_clock_a_hz;
      o_synth_cfg.clk_b_hz <= i_synth1_clock_b_hz;
      o_synth_cfg.frame_hz <= i_synth0_frame_pulse_b_hz;
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  sequence s_hold_mode;
    !dev_rst && eff_mode == tlcs_pkg::TLCS_MODE_HOLDOVER;
  endsequence

  sequence s_realign_done;
    !o_hitless_switch ##1 !o_realign_pulse;
  endsequence

  a_hold_follows: assert property (@(posedge i_clk)
    disable iff (i_reset) s_hold_mode |=> o_hold)
    else $error("hold not raised");
  a_lock_needs_ref: assert property (@(posedge i_clk)
    disable iff (i_reset) o_lock |-> $past(pin_st[6]) && !o_hold)
    else $error("bad lock");
  a_reset_follows: assert property (@(posedge i_clk)
    disable iff (i_reset) dev_rst |=> o_device_reset)
    else $error("reset lost");
  a_drv0_follow: assert property (@(posedge i_clk)
    disable iff (i_reset) o_diff_out0_drive == $past(pin_st[4]))
    else $error("drv0");
  a_drv1_follow: assert property (@(posedge i_clk)
    disable iff (i_reset) o_diff_out1_drive == $past(pin_st[5]))
    else $error("drv1");
  a_ref_copy: assert property (@(posedge i_clk)
    disable iff (i_reset) o_ref_out == $past(pin_st[7]))
    else $error("ref copy");
  a_strap_mode: assert property (@(posedge i_clk)
    disable iff (i_reset) dev_rst |=>
      mode_reg_ff[tlcs_pkg::MODE_MSB:tlcs_pkg::MODE_LSB] == $past(mode_pin))
    else $error("strap");
  a_realign_edge: assert property (@(posedge i_clk)
    disable iff (i_reset) o_realign_pulse |-> s_realign_done)
    else $error("realign");
  a_cfg_default: assert property (@(posedge i_clk)
    disable iff (i_reset) dev_rst |=>
      o_synth_cfg.clk_a_hz == 32'(tlcs_pkg::SYNTH1_A_DEF_HZ))
    else $error("default");
  a_hitless_on: assert property (@(posedge i_clk)
    disable iff (i_reset) (eff_hs && !dev_rst) |=> o_hitless_switch)
    else $error("hs");
  a_reg_write: assert property (@(posedge i_clk)
    disable iff (i_reset) (!dev_rst && i_reg_req.wr && reg_hit) |=>
      mode_reg_ff == $past(i_reg_req.wdata))
    else $error("mode write lost");

endmodule : tlcs_ctrl

// File: tlcs_pkg.sv
// Package with constants and types for the transmit loop control and status pins.
package tlcs_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] TX_LOOP_MODE_ADDR = 8'h1f;
  localparam logic [7:0] TX_LOOP_MODE_RESET = 8'h00;
  localparam int MODE_LSB = 0;
  localparam int MODE_MSB = 1;
  localparam int MODE_SRC_BIT = 7;
  localparam int HITLESS_SW_BIT = 6;
  localparam int HITLESS_SRC_BIT = 5;

  // ==========================================================================
  // Mode encoding
  // ==========================================================================
  typedef enum logic [1:0] {
    TLCS_MODE_AUTO = 2'h0,
    TLCS_MODE_NORMAL = 2'h1,
    TLCS_MODE_HOLDOVER = 2'h2,
    TLCS_MODE_FREERUN = 2'h3
  } tlcs_mode_e;

  // ==========================================================================
  // Timing and frequency defaults
  // ==========================================================================
  localparam int CLK_PERIOD_PS = 8000;
  localparam int RESET_MIN_NS = 300;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS * 1000 + CLK_PERIOD_PS - 1) /
                                 CLK_PERIOD_PS;
  localparam int SYNTH_STEP_HZ = 8000;
  localparam int SYNTH_MAX_HZ = 100000000;
  localparam int SYNTH_LOW_HZ = 2000;
  localparam int SYNTH1_A_DEF_HZ = 1544000;
  localparam int SYNTH1_B_DEF_HZ = 3088000;
  localparam int FRAME_DEF_HZ = 8000;

  // ==========================================================================
  // Carriers
  // ==========================================================================
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } tlcs_reg_req_s;

  typedef struct packed {
    logic [31:0] clk_a_hz;
    logic [31:0] clk_b_hz;
    logic [31:0] frame_hz;
  } tlcs_synth_cfg_s;

endpackage : tlcs_pkg

// File: tlcs_host_model.sv
// Board controller model that drives the control pins of the block.
`timescale 1ns/1ps

module tlcs_host_model (
  input wire logic i_clk,
  input wire logic i_rst_req,
  input wire logic [5:0] i_pins,
  output logic o_reset_n_pin,
  output logic [5:0] o_pins
);
  int cnt_ff = tlcs_pkg::RESET_MIN_CYC;

  // The reset pin is held low for the minimum time, at power-up too.
  always @(posedge i_clk) begin
    if (i_rst_req) begin
      cnt_ff <= tlcs_pkg::RESET_MIN_CYC;
    end else if (cnt_ff > 0) begin
      cnt_ff <= cnt_ff - 1;
    end
  end

  assign o_reset_n_pin = (cnt_ff == 0);
  assign o_pins = i_pins;
endmodule : tlcs_host_model

// File: tb_tlcs_ctrl.sv
// Self-checking testbench for the control and status pin block.
`timescale 1ns/1ps

module tb_tlcs_ctrl;
  logic i_clk = 1'b0;
  logic i_reset = 1'b1;
  logic rst_req = 1'b0;
  logic [5:0] pins = 6'h1d;
  logic lk = 1'b0;
  logic rx = 1'b0;
  logic cfg_wr = 1'b0;
  logic [31:0] fa = 32'h0000_0000;
  logic [31:0] fb = 32'h0000_0000;
  logic [31:0] fr = 32'h0000_0000;
  logic [31:0] na;
  logic [31:0] nb;
  logic [95:0] ex;
  tlcs_pkg::tlcs_reg_req_s req = '0;
  tlcs_pkg::tlcs_synth_cfg_s cfg;
  logic rn, dev_rst, hs, rlg, d0, d1, lock, hold, ref_o, rv;
  logic [5:0] pin_o;
  logic [1:0] mode;
  logic [7:0] rd;
  logic [7:0] v;
  int err_total = 0;
  int comparisons = 0;
  int n;

  always #4 i_clk = ~i_clk;

  tlcs_host_model u_host (.i_clk(i_clk), .i_rst_req(rst_req),
    .i_pins(pins), .o_reset_n_pin(rn), .o_pins(pin_o));

  tlcs_ctrl u_dut (.i_clk(i_clk), .i_reset(i_reset), .i_reset_n_pin(rn),
    .i_hitless_switch_enable(pin_o[0]), .i_mode_sel(pin_o[2:1]),
    .i_diff_out0_enable(pin_o[3]), .i_diff_out1_enable(pin_o[4]),
    .i_loop_locked(lk), .i_rx_ref_sel(rx), .i_reg_req(req),
    .i_synth1_clock_a_hz(fa), .i_synth1_clock_b_hz(fb),
    .i_synth0_frame_pulse_b_hz(fr), .i_synth_cfg_wr(cfg_wr),
    .o_device_reset(dev_rst), .o_hitless_switch(hs),
    .o_realign_pulse(rlg), .o_tx_loop_mode(mode),
    .o_diff_out0_drive(d0), .o_diff_out1_drive(d1), .o_lock(lock),
    .o_hold(hold), .o_ref_out(ref_o), .o_reg_rdata(rd),
    .o_reg_rvalid(rv), .o_synth_cfg(cfg));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic ok_a(input logic [31:0] f);
    return (f % tlcs_pkg::SYNTH_STEP_HZ == 0 && f > 0 &&
            f <= tlcs_pkg::SYNTH_MAX_HZ) ||
           f == tlcs_pkg::SYNTH_LOW_HZ;
  endfunction : ok_a

  function automatic logic ok_b(input logic [31:0] a, input logic [31:0] b);
    return b >= tlcs_pkg::SYNTH_LOW_HZ && b <= tlcs_pkg::SYNTH_MAX_HZ &&
           (b % a == 0 || a % b == 0);
  endfunction : ok_b

  task automatic chk(input logic [95:0] seen, input logic [95:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %0h want %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge i_clk);
    #1;
  endtask : cyc

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    cyc(1);
    req = '0;
    cyc(1);
  endtask : reg_wr

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    req = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    d = 8'hxx;
    cyc(1);
    req = '0;
    for (int i = 0; i < 2; i++) begin
      if (rv === 1'b1) d = rd;
      cyc(1);
    end
  endtask : reg_rd

  task automatic wait_out;
    for (n = 0; n < 100 && dev_rst !== 1'b0; n++) cyc(1);
    chk(dev_rst, 1'b0);
  endtask : wait_out

  task automatic test_done;
    $display("Checks %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge i_clk);
    err_total++;
    test_done;
  end

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    void'($urandom(78));
    cyc(3);
    chk(dev_rst, 1'b1);
    ex = {tlcs_pkg::SYNTH1_A_DEF_HZ, tlcs_pkg::SYNTH1_B_DEF_HZ,
          tlcs_pkg::FRAME_DEF_HZ};
    chk(cfg.clk_a_hz, ex[95:64]);
    chk(cfg.clk_b_hz, ex[63:32]);
    chk(cfg.frame_hz, ex[31:0]);
    i_reset = 1'b0;
    wait_out;
    chk(mode, tlcs_pkg::TLCS_MODE_HOLDOVER);
    chk(hold, 1'b1);
    reg_rd(tlcs_pkg::TX_LOOP_MODE_ADDR, v);
    chk(v, {6'h00, tlcs_pkg::TLCS_MODE_HOLDOVER});
    for (int k = 0; k < 40; k++) begin
      pins = 6'($urandom);
      lk = 1'($urandom);
      rx = 1'($urandom);
      cyc(6);
      chk(mode, pins[2:1]);
      chk({d1, d0}, pins[4:3]);
      chk(lock, lk && !pins[2]);
      chk(hold, pins[2:1] == 2'h2);
      chk(ref_o, rx);
      chk(hs, pins[0]);
    end
    pins[0] = 1'b1;
    lk = 1'b1;
    cyc(6);
    pins[0] = 1'b0;
    v = 8'h00;
    for (int k = 0; k < 8; k++) begin
      cyc(1);
      if (rlg === 1'b1) v++;
    end
    chk(v, 8'h01);
    chk(hs, 1'b0);
    reg_wr(tlcs_pkg::TX_LOOP_MODE_ADDR, 8'he3);
    reg_rd(tlcs_pkg::TX_LOOP_MODE_ADDR, v);
    chk(v, 8'he3);
    cyc(2);
    chk(mode, tlcs_pkg::TLCS_MODE_FREERUN);
    chk(hs, 1'b1);
    chk(lock, 1'b0);
    reg_rd(8'h20, v);
    chk(v, 8'h00);
    reg_wr(tlcs_pkg::TX_LOOP_MODE_ADDR, 8'h00);
    for (int k = 0; k < 8; k++) begin
      na = tlcs_pkg::SYNTH_STEP_HZ * $urandom_range(12500, 1);
      if (k == 0) na = tlcs_pkg::SYNTH_LOW_HZ;
      if (k == 1) na = tlcs_pkg::SYNTH_STEP_HZ + 1;
      if (k == 2) na = tlcs_pkg::SYNTH_MAX_HZ + tlcs_pkg::SYNTH_STEP_HZ;
      nb = (k == 3) ? 32'h0000_03e8 : na;
      if (k == 4) nb = na / 2;
      fa = na;
      fb = nb;
      fr = $urandom_range(16000, 2000);
      cfg_wr = 1'b1;
      cyc(1);
      cfg_wr = 1'b0;
      cyc(1);
      if (ok_a(fa) && ok_b(fa, fb)) ex = {fa, fb, fr};
      chk(cfg.clk_a_hz, ex[95:64]);
      chk(cfg.clk_b_hz, ex[63:32]);
      chk(cfg.frame_hz, ex[31:0]);
    end
    pins[2:1] = 2'h1;
    rst_req = 1'b1;
    cyc(1);
    rst_req = 1'b0;
    cyc(8);
    chk(dev_rst, 1'b1);
    ex = {tlcs_pkg::SYNTH1_A_DEF_HZ, tlcs_pkg::SYNTH1_B_DEF_HZ,
          tlcs_pkg::FRAME_DEF_HZ};
    chk(cfg.clk_a_hz, ex[95:64]);
    chk(cfg.clk_b_hz, ex[63:32]);
    wait_out;
    reg_rd(tlcs_pkg::TX_LOOP_MODE_ADDR, v);
    chk(v, {6'h00, pins[2:1]});
    chk(mode, pins[2:1]);
    test_done;
  end
endmodule : tb_tlcs_ctrl
